// [src/scd_pkg.sv]
package scd_pkg;
	// Register offset
	localparam logic [7:0] SCD_DIVISOR_ADDR = 8'h95;
	localparam logic [7:0] SCD_DIVISOR_RST  = 8'h00;
	// Configuration byte field positions and unprogrammed value
	localparam int         SCD_CFG_SRC_LO   = 0;
	localparam int         SCD_CFG_SRC_HI   = 1;
	localparam int         SCD_CFG_RCFS     = 3;
	localparam int         SCD_CFG_FILT     = 4;
	localparam logic [7:0] SCD_CFG_UNPROG   = 8'hff;
	// Source encodings
	localparam logic [1:0] SCD_SRC_EXT      = 2'h0;
	localparam logic [1:0] SCD_SRC_XTAL     = 2'h1;
	localparam logic [1:0] SCD_SRC_RSVD     = 2'h2;
	localparam logic [1:0] SCD_SRC_RC       = 2'h3;
	// Filter depth in cycles
	localparam int         SCD_FILT_LEN     = 3;

	typedef enum logic [1:0] {
		SCD_ST_UNDIV = 2'b01,
		SCD_ST_DIV   = 2'b10
	} scd_state_t;
endpackage : scd_pkg

// [src/scd_clock_divider.sv]
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module scd_clock_divider
	import scd_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] cfg_byte_i,
	input  wire logic       rc_tick_i,
	input  wire logic       xtal_in_pin_i,
	output logic            xtal_out_pin_o,
	output logic            xtal_out_pin_oe_o,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	output logic            osc_tick_o,
	output logic            sys_clk_en_o,
	output logic      [1:0] osc_source_sel_o,
	output logic            cfg_reserved_o
);
	logic [7:0]              cfg_q;
	logic [7:0]              sys_clk_divisor_q;
	logic [7:0]              div_active_q;
	logic [7:0]              cnt_q;
	logic                    phase_q;
	logic                    rc_half_q;
	logic [SCD_FILT_LEN-1:0] filt_sh_q;
	logic                    filt_lvl_q;
	logic                    xin_prev_q;
	logic                    osc_tick;
	logic                    xin_lvl;
	logic                    xin_rise;
	logic                    rc_tick;
	logic                    boundary;
	scd_state_t              state_q;

	// Configuration captured on the first clock after reset is released; all ones while unprogrammed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q <= SCD_CFG_UNPROG;
		end else if (cfg_q == SCD_CFG_UNPROG) begin
			cfg_q <= cfg_byte_i;
		end
	end

	// RC halving path
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rc_half_q <= 1'b0;
		end else if (rc_tick_i) begin
			rc_half_q <= ~rc_half_q;
		end
	end
	assign rc_tick = cfg_q[SCD_CFG_RCFS] ? rc_tick_i
		: (rc_tick_i & rc_half_q);

	// Crystal input noise filter: level must hold for the full depth
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			filt_sh_q  <= '0;
			filt_lvl_q <= 1'b0;
			xin_prev_q <= 1'b0;
		end else begin
			filt_sh_q <= {filt_sh_q[SCD_FILT_LEN-2:0], xtal_in_pin_i};
			if (&filt_sh_q) begin
				filt_lvl_q <= 1'b1;
			end else if (~|filt_sh_q) begin
				filt_lvl_q <= 1'b0;
			end
			xin_prev_q <= xin_lvl;
		end
	end
	assign xin_lvl  = cfg_q[SCD_CFG_FILT] ? filt_lvl_q
		: xtal_in_pin_i;
	assign xin_rise = xin_lvl & ~xin_prev_q;

	// Source select
	always_comb begin
		case (cfg_q[SCD_CFG_SRC_HI:SCD_CFG_SRC_LO])
			SCD_SRC_RC:   osc_tick = rc_tick;
			SCD_SRC_XTAL: osc_tick = xin_rise;
			SCD_SRC_EXT:  osc_tick = xin_rise;
			default:      osc_tick = 1'b0;
		endcase
	end
	assign osc_tick_o       = osc_tick;
	assign osc_source_sel_o = cfg_q[SCD_CFG_SRC_HI:SCD_CFG_SRC_LO];
	assign cfg_reserved_o   = (osc_source_sel_o == SCD_SRC_RSVD);

	// Amplifier drives out pin only in crystal mode
	assign xtal_out_pin_oe_o = (osc_source_sel_o == SCD_SRC_XTAL);
	assign xtal_out_pin_o    = ~xtal_in_pin_i & xtal_out_pin_oe_o;

	// Divisor register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_clk_divisor_q <= SCD_DIVISOR_RST;
		end else if (wr_i && addr_i == SCD_DIVISOR_ADDR) begin
			sys_clk_divisor_q <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			rdata_o <= (addr_i == SCD_DIVISOR_ADDR)
				? sys_clk_divisor_q : 8'h00;
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Divider: for N above zero, half period of N+1 ticks, two halves per output period; N of zero gives one tick per period
	assign boundary = (div_active_q == 8'h00) ? osc_tick
		: (osc_tick && cnt_q == div_active_q && phase_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_active_q <= SCD_DIVISOR_RST;
			state_q      <= SCD_ST_UNDIV;
		end else if (boundary) begin
			div_active_q <= sys_clk_divisor_q;
			state_q <= (sys_clk_divisor_q == 8'h00) ? SCD_ST_UNDIV
				: SCD_ST_DIV;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || boundary) begin
			cnt_q   <= 8'h00;
			phase_q <= 1'b0;
		end else if (osc_tick) begin
			if (cnt_q == div_active_q) begin
				cnt_q   <= 8'h00;
				phase_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	always_comb begin
		case (state_q)
			SCD_ST_UNDIV: sys_clk_en_o = osc_tick;
			SCD_ST_DIV:   sys_clk_en_o = boundary;
			default:      sys_clk_en_o = 1'b0;
		endcase
	end

	// Independent tick count per system period for the ratio checks
	logic [9:0] ref_ticks_q;
	logic [7:0] ref_div_q;
	logic       ref_valid_q;
	logic [9:0] ref_exp;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_ticks_q <= 10'h000;
			ref_div_q   <= 8'h00;
			ref_valid_q <= 1'b0;
		end else if (sys_clk_en_o) begin
			ref_ticks_q <= 10'h000;
			ref_div_q   <= sys_clk_divisor_q;
			ref_valid_q <= 1'b1;
		end else if (osc_tick) begin
			ref_ticks_q <= ref_ticks_q + 10'h001;
		end
	end

	// One tick per period undivided, otherwise twice the divisor plus two
	assign ref_exp = (ref_div_q == 8'h00) ? 10'h001
		: {1'b0, ref_div_q, 1'b0} + 10'h002;

	// Raw RC ticks skipped since the last passed one
	logic [1:0] rc_skip_q;
	logic       rc_seen_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rc_skip_q <= 2'h0;
			rc_seen_q <= 1'b0;
		end else if (osc_tick) begin
			rc_skip_q <= 2'h0;
			rc_seen_q <= ~cfg_q[SCD_CFG_RCFS];
		end else if (rc_tick_i && rc_skip_q != 2'h3) begin
			rc_skip_q <= rc_skip_q + 2'h1;
		end
	end

	a_div_reset: assert property (@(posedge clk_i)
		rst_i |=> sys_clk_divisor_q == 8'h00)
		else $error("divisor not cleared by reset");
	a_div_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == SCD_DIVISOR_ADDR |=> sys_clk_divisor_q == $past(wdata_i))
		else $error("divisor write lost");
	a_undiv_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		div_active_q == 8'h00 |-> sys_clk_en_o == osc_tick)
		else $error("undivided clock mismatch");
	a_div_ratio: assert property (@(posedge clk_i) disable iff (rst_i)
		sys_clk_en_o && div_active_q != 8'h00 |-> cnt_q == div_active_q && phase_q)
		else $error("divided pulse off ratio");
	a_switch_bound: assert property (@(posedge clk_i) disable iff (rst_i)
		div_active_q != $past(div_active_q) |-> $past(boundary))
		else $error("divisor applied mid period");
	a_rc_source: assert property (@(posedge clk_i) disable iff (rst_i)
		osc_source_sel_o == SCD_SRC_RC |-> osc_tick == rc_tick)
		else $error("rc not selected");
	a_xtal_source: assert property (@(posedge clk_i) disable iff (rst_i)
		osc_source_sel_o == SCD_SRC_XTAL |-> osc_tick == xin_rise && xtal_out_pin_oe_o)
		else $error("crystal not selected");
	a_ext_source: assert property (@(posedge clk_i) disable iff (rst_i)
		osc_source_sel_o == SCD_SRC_EXT |-> osc_tick == xin_rise && !xtal_out_pin_oe_o)
		else $error("external clock not selected");
	a_rc_half: assert property (@(posedge clk_i) disable iff (rst_i)
		osc_source_sel_o == SCD_SRC_RC && !cfg_q[SCD_CFG_RCFS] && osc_tick
		|=> !osc_tick)
		else $error("rc halving broken");
	a_filt_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
		!cfg_q[SCD_CFG_FILT] |-> xin_lvl == xtal_in_pin_i)
		else $error("filter not bypassed");
	a_cfg_default: assert property (@(posedge clk_i)
		rst_i |=> cfg_q == SCD_CFG_UNPROG)
		else $error("config default wrong");

	// Period length and register port checks
	a_period_len: assert property (@(posedge clk_i) disable iff (rst_i)
		sys_clk_en_o && ref_valid_q |-> ref_ticks_q + 10'h001 == ref_exp)
		else $error("system period length wrong");
	a_period_cap: assert property (@(posedge clk_i) disable iff (rst_i)
		osc_tick && !sys_clk_en_o && ref_valid_q |-> ref_ticks_q + 10'h001 < ref_exp)
		else $error("system pulse missed");
	a_en_on_tick: assert property (@(posedge clk_i) disable iff (rst_i)
		sys_clk_en_o |-> osc_tick)
		else $error("system pulse without tick");
	a_switch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!boundary |=> $stable(div_active_q))
		else $error("divisor changed off boundary");
	a_rd_data: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == SCD_DIVISOR_ADDR |=> rdata_o == $past(sys_clk_divisor_q))
		else $error("divisor read wrong");
	a_rd_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i != SCD_DIVISOR_ADDR |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_rd_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		!rd_i |=> rdata_o == 8'h00)
		else $error("read data not cleared");
	a_div_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wr_i && addr_i == SCD_DIVISOR_ADDR) |=> $stable(sys_clk_divisor_q))
		else $error("divisor changed without write");

	// Source, pin and filter checks
	a_rsv_silent: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_reserved_o |-> !osc_tick && !sys_clk_en_o)
		else $error("reserved source ticking");
	a_xout_invert: assert property (@(posedge clk_i) disable iff (rst_i)
		xtal_out_pin_oe_o |-> xtal_out_pin_o == !xtal_in_pin_i)
		else $error("amplifier not inverting");
	a_xout_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		!xtal_out_pin_oe_o |-> !xtal_out_pin_o)
		else $error("amplifier active when off");
	a_rc_full: assert property (@(posedge clk_i) disable iff (rst_i)
		osc_source_sel_o == SCD_SRC_RC && cfg_q[SCD_CFG_RCFS] |-> osc_tick == rc_tick_i)
		else $error("rc full rate broken");
	a_rc_skip: assert property (@(posedge clk_i) disable iff (rst_i)
		osc_source_sel_o == SCD_SRC_RC && !cfg_q[SCD_CFG_RCFS] && osc_tick && rc_seen_q
		|-> rc_skip_q == 2'h1)
		else $error("rc halving ratio wrong");
	a_filt_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_q[SCD_CFG_FILT] && |filt_sh_q && !(&filt_sh_q)
		|=> $stable(filt_lvl_q))
		else $error("filter passed a glitch");
	a_filt_path: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_q[SCD_CFG_FILT] |-> xin_lvl == filt_lvl_q)
		else $error("filter not inserted");
	a_cfg_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_q != SCD_CFG_UNPROG |=> $stable(cfg_q))
		else $error("config changed after capture");

	c_div_change: cover property (@(posedge clk_i) disable iff (rst_i)
		boundary && sys_clk_divisor_q != div_active_q);
	c_divided: cover property (@(posedge clk_i) disable iff (rst_i)
		sys_clk_en_o && state_q == SCD_ST_DIV);
	c_xtal: cover property (@(posedge clk_i) disable iff (rst_i)
		osc_source_sel_o == SCD_SRC_XTAL && sys_clk_en_o);
	c_rc_half: cover property (@(posedge clk_i) disable iff (rst_i)
		osc_source_sel_o == SCD_SRC_RC && !cfg_q[SCD_CFG_RCFS] && osc_tick);
	c_filtered: cover property (@(posedge clk_i) disable iff (rst_i)
		cfg_q[SCD_CFG_FILT] && xin_rise);
endmodule : scd_clock_divider

// [tb/scd_clock_divider_bench.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module scd_clock_divider_bench;
	import scd_pkg::*;
	logic       clk_i = 0, rst_i = 1, rc_tick_i = 1, xtal_in_pin_i = 0;
	logic       wr_i = 0, rd_i = 0, rd_d = 0, xo, oe, ot, en, rsv;
	logic [7:0] cfg_byte_i = SCD_CFG_UNPROG, addr_i = 0, wdata_i = 0;
	logic [7:0] rdata_o, v, e_rd;
	logic [1:0] src;
	logic [7:0] exp_q[$];
	int         err_count = 0, n_checks = 0, cyc = 0, k, a, b;
	scd_clock_divider scd_clock_divider_inst (.clk_i(clk_i), .rst_i(rst_i),
		.cfg_byte_i(cfg_byte_i), .rc_tick_i(rc_tick_i),
		.xtal_in_pin_i(xtal_in_pin_i), .xtal_out_pin_o(xo),
		.xtal_out_pin_oe_o(oe), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc_tick_o(ot),
		.sys_clk_en_o(en), .osc_source_sel_o(src), .cfg_reserved_o(rsv));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task do_reset(input logic [7:0] c);
		rst_i <= 1;
		cfg_byte_i <= c;
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		repeat (2) @(posedge clk_i);
	endtask : do_reset
	task wr(input logic [7:0] ad, input logic [7:0] d);
		wr_i <= 1; addr_i <= ad; wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 0;
	endtask : wr
	task rd(input logic [7:0] ad, input logic [7:0] e);
		rd_i <= 1; addr_i <= ad; exp_q.push_back(e);
		@(posedge clk_i);
		rd_i <= 0;
	endtask : rd
	task cnt(input int c, output int o, output int e);
		o = 0; e = 0;
		repeat (c) begin
			@(negedge clk_i); o += (ot === 1'b1); e += (en === 1'b1);
		end
	endtask : cnt
	// Osc ticks from one system enable pulse to the next
	task gap(output int n);
		int i;
		n = 0; i = 0;
		do begin @(negedge clk_i); i++; end while (en !== 1'b1 && i < 2000);
		do begin
			@(negedge clk_i); n += (ot === 1'b1); i++;
		end while (en !== 1'b1 && i < 4000);
	endtask : gap
	task pls(input int len, output int n);
		n = 0;
		for (int i = 0; i < len + 10; i++) begin
			@(posedge clk_i); xtal_in_pin_i <= (i >= 5 && i < 5 + len);
			@(negedge clk_i); n += (ot === 1'b1);
		end
	endtask : pls
	// Read data are compared one cycle after the read strobe
	always @(posedge clk_i) begin
		rd_d <= rd_i;
		if (rd_d && exp_q.size() > 0) begin
			e_rd = exp_q.pop_front();
			`CHK(rdata_o, e_rd)
		end
		cyc++;
		if (cyc == 20000) begin err_count++; give_verdict(); end
	end
	initial begin
		void'($urandom(11487));
		do_reset(8'hff);
		`CHK(src, SCD_SRC_RC)
		`CHK(oe, 1'b0)
		rd(SCD_DIVISOR_ADDR, SCD_DIVISOR_RST);
		cnt(20, a, b);
		`CHK(a, 20)
		`CHK(b, 20)
		for (k = 0; k < 4; k++) begin
			v = (k == 3) ? 8'hff : 8'h01 + 8'($urandom % 6);
			wr(SCD_DIVISOR_ADDR, v);
			rd(8'h96, 8'h00);
			wr(8'h94, 8'h5a);
			rd(SCD_DIVISOR_ADDR, v);
			gap(a);
			gap(a);
			`CHK(a, 2 * (v + 1))
		end
		$display("divider and register test done");
		do_reset(8'hf7);
		cnt(20, a, b);
		`CHK(a, 10)
		do_reset(8'he9);
		`CHK(oe, 1'b1)
		repeat (8) begin
			@(posedge clk_i); xtal_in_pin_i <= 1'($urandom % 2);
			@(negedge clk_i); `CHK(xo, ~xtal_in_pin_i)
		end
		pls(1, a);
		`CHK(a, 1)
		do_reset(8'hf9);
		pls(1, a);
		`CHK(a, 0)
		pls(6, a);
		`CHK(a, 1)
		do_reset(8'hec);
		`CHK(oe, 1'b0)
		pls(2, a);
		`CHK(a, 1)
		do_reset(8'hfa);
		`CHK(rsv, 1'b1)
		cnt(20, a, b);
		`CHK(a, 0)
		$display("source selection test done");
		give_verdict();
	end
endmodule : scd_clock_divider_bench
